// ==== logic/pci_status_defines.svh ====
// constants for the pci status flag block: register offsets, bit positions,
// fixed field values and target decode slots.
// assumes an 8-bit register address on the plain register port.
`ifndef PCI_STATUS_DEFINES_SVH
`define PCI_STATUS_DEFINES_SVH

// ************************************************************
// register offsets
// ************************************************************
`define OFS_STATUS_CMD   8'h04
`define OFS_IRQ_STATUS   8'h10
`define OFS_IRQ_CLEAR    8'h14
`define OFS_IRQ_ENABLE   8'h18

// ************************************************************
// status and command word layout
// ************************************************************
`define BIT_SYS_ERR      30
`define BIT_MABORT_RX    29
`define BIT_TABORT_RX    28
`define BIT_TABORT_TX    27
`define DEVSEL_HI        26
`define DEVSEL_LO        25
`define BIT_INIT_PARITY  24
`define BIT_B2B_CAP      23
`define BIT_66M_CAP      21
`define BIT_CAP_LIST     20
`define BIT_PARITY_RESP  6
`define BIT_RSVD_HI      22
`define RSVD_LOW_HI      19
`define RSVD_LOW_LO      10
`define DEVSEL_MEDIUM    2'h1

// ************************************************************
// flag vector and interrupt register layout
// ************************************************************
`define NUM_FLAGS        5
`define FLAG_SYS_ERR     0
`define FLAG_MABORT_RX   1
`define FLAG_TABORT_RX   2
`define FLAG_TABORT_TX   3
`define FLAG_INIT_PARITY 4

// ************************************************************
// target decode
// ************************************************************
`define CMD_CFG_READ     4'ha
`define CMD_CFG_WRITE    4'hb
`define SLOT_MEDIUM      2'h2
`define SLOT_SLOW        2'h3

`endif

// ==== logic/pci_status_pkg.sv ====
// types shared by the pci status flag block.
// assumes pci_status_defines.svh holds the numeric constants.
package pci_status_pkg;

  typedef enum logic [1:0] {
    DS_IDLE  = 2'b00,
    DS_COUNT = 2'b01,
    DS_DRIVE = 2'b10
  } devsel_state_t;

endpackage

// ==== logic/sync_bits.sv ====
// two flip-flop synchroniser for a group of pin levels.
// assumes the inputs are levels that hold for several clk_sys cycles.
`timescale 1ns/100ps

module sync_bits #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // levels
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_syncOut;

  always_comb begin
    next_stage1  = pinIn;
    next_syncOut = stage1;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage1  <= '0;
      syncOut <= '0;
    end else begin
      stage1  <= next_stage1;
      syncOut <= next_syncOut;
    end
  end

endmodule

// ==== logic/devsel_timer.sv ====
// target decode timer: drives devsel low in the medium slot after the
// address phase, or the slow slot for configuration commands.
// assumes all pci inputs are already synchronised and pciEdge marks one
// rising pci clock edge.
`timescale 1ns/100ps

`include "pci_status_defines.svh"

module devsel_timer
  import pci_status_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // sampled pci bus
  input  wire logic       pciEdge,
  input  wire logic       frameLow,
  input  wire logic [3:0] busCmd,
  input  wire logic       addrHit,
  input  wire logic       transEnd,
  // devsel pin
  output logic            devselNOut,
  output logic            devselOe
);

  devsel_state_t state;
  devsel_state_t next_state;
  logic [1:0]    cnt;
  logic [1:0]    next_cnt;
  logic [1:0]    slot;
  logic [1:0]    next_slot;
  logic          framePrev;
  logic          next_framePrev;
  logic          next_devselOe;
  logic          isCfg;

  assign isCfg = (busCmd == `CMD_CFG_READ) || (busCmd == `CMD_CFG_WRITE);

  always_comb begin
    next_state     = state;
    next_cnt       = cnt;
    next_slot      = slot;
    next_framePrev = framePrev;
    next_devselOe  = devselOe;
    if (pciEdge) begin
      next_framePrev = frameLow;
      case (state)
        DS_IDLE: begin
          if (frameLow && !framePrev && addrHit) begin
            next_cnt   = 2'h0;
            // configuration may answer later; all else by medium
            next_slot  = isCfg ? `SLOT_SLOW : `SLOT_MEDIUM;
            next_state = DS_COUNT;
          end
        end
        DS_COUNT: begin
          next_cnt = cnt + 2'h1;
          if (cnt + 2'h1 == slot) begin
            next_devselOe = 1'b1;
            next_state    = DS_DRIVE;
          end
        end
        DS_DRIVE: begin
          if (transEnd) begin
            next_devselOe = 1'b0;
            next_state    = DS_IDLE;
          end
        end
        default: begin
          next_devselOe = 1'b0;
          next_state    = DS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state      <= DS_IDLE;
      cnt        <= 2'h0;
      slot       <= `SLOT_MEDIUM;
      framePrev  <= 1'b0;
      devselOe   <= 1'b0;
      devselNOut <= 1'b1;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      slot       <= next_slot;
      framePrev  <= next_framePrev;
      devselOe   <= next_devselOe;
      devselNOut <= ~next_devselOe;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_devsel_medium: assert property (
    $rose(devselOe) && slot == `SLOT_MEDIUM |-> cnt == `SLOT_MEDIUM)
    else $error("devsel not driven in the medium slot");
  a_devsel_pin_low: assert property (
    devselOe |-> !devselNOut)
    else $error("devsel driven but not low");

endmodule

// ==== logic/pci_status_flags.sv ====
// pci status flags: upper status half of the status and command word,
// the parity response enable, interrupt flags and target decode timing.
// assumes the pci clock and bus pins arrive unsynchronised; every pin is
// sampled on clk_sys and acted on at a rising pci clock edge.
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/100ps

`include "pci_status_defines.svh"

module pci_status_flags
  import pci_status_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  // interrupt
  output logic             irq,
  // pci clock and observed pins
  input  wire logic        pciClk,
  input  wire logic        serrN,
  input  wire logic        perrN,
  input  wire logic        frameN,
  input  wire logic [3:0]  busCmd,
  // pci engine status lines
  input  wire logic        isMaster,
  input  wire logic        specialCycle,
  input  wire logic        masterAbort,
  input  wire logic        targetAbortIn,
  input  wire logic        targetAbortOut,
  input  wire logic        addrHit,
  input  wire logic        transEnd,
  // devsel pin
  output logic             devselNOut,
  output logic             devselOe
);

  localparam int NIN = 13;

  // ************************************************************
  // pin sampling
  // ************************************************************
  logic [NIN-1:0] pinRaw;
  logic [NIN-1:0] pinSync;
  logic           pciClkS;
  logic           serrLow;
  logic           perrLow;
  logic           frameLow;
  logic [3:0]     cmdS;
  logic           masterS;
  logic           specialS;
  logic           mAbortS;
  logic           tAbortInS;
  logic           tAbortOutS;
  logic           hitS;
  logic           endS;
  logic           pciClkPrev;
  logic           pciEdge;

  assign pinRaw = {pciClk, ~serrN, ~perrN, ~frameN, busCmd, isMaster,
                   specialCycle, masterAbort, targetAbortIn, targetAbortOut};

  // the link lines and engine status, all but hit and end, cross in together
  sync_bits #(.WIDTH(NIN)) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pinIn   (pinRaw),
    .syncOut (pinSync)
  );

  assign {pciClkS, serrLow, perrLow, frameLow, cmdS, masterS,
          specialS, mAbortS, tAbortInS, tAbortOutS} = pinSync;

  // decode hit and end come from logic on clk_sys, so no sync
  assign hitS = addrHit;
  assign endS = transEnd;

  // a pci clock already high at reset release gives one early edge; it
  // is harmless, the pins are sampled in mid-phase where they stand still
  assign pciEdge = pciClkS && !pciClkPrev;

  // ************************************************************
  // events at each pci edge
  // ************************************************************
  logic                  parity_response_enable;
  logic [`NUM_FLAGS-1:0] ev;

  always_comb begin
    ev = '0;
    if (pciEdge) begin
      ev[`FLAG_SYS_ERR]   = serrLow;
      ev[`FLAG_MABORT_RX] = mAbortS && !specialS;
      ev[`FLAG_TABORT_RX] = tAbortInS && masterS;
      ev[`FLAG_TABORT_TX] = tAbortOutS && !masterS;
      // parity ignored entirely while response disabled
      ev[`FLAG_INIT_PARITY] = perrLow && masterS && parity_response_enable;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  logic [`NUM_FLAGS-1:0] flags;
  logic [`NUM_FLAGS-1:0] next_flags;
  logic [`NUM_FLAGS-1:0] irqEn;
  logic [`NUM_FLAGS-1:0] next_irqEn;
  logic [`NUM_FLAGS-1:0] clr;
  logic                  next_parity_response_enable;
  logic                  next_pciClkPrev;
  logic [31:0]           next_regRdata;
  logic [31:0]           statusWord;
  logic                  next_irq;

  always_comb begin
    statusWord                   = 32'h0000_0000;
    statusWord[`BIT_SYS_ERR]     = flags[`FLAG_SYS_ERR];
    statusWord[`BIT_MABORT_RX]   = flags[`FLAG_MABORT_RX];
    statusWord[`BIT_TABORT_RX]   = flags[`FLAG_TABORT_RX];
    statusWord[`BIT_TABORT_TX]   = flags[`FLAG_TABORT_TX];
    statusWord[`DEVSEL_HI:`DEVSEL_LO] = `DEVSEL_MEDIUM;
    statusWord[`BIT_INIT_PARITY] = flags[`FLAG_INIT_PARITY];
    statusWord[`BIT_B2B_CAP]     = 1'b1;
    statusWord[`BIT_66M_CAP]     = 1'b1;
    statusWord[`BIT_CAP_LIST]    = 1'b1;
    statusWord[`BIT_PARITY_RESP] = parity_response_enable;
  end

  always_comb begin
    clr = '0;
    if (regWr && regAddr == `OFS_STATUS_CMD) begin
      // write one to clear; fixed and reserved bits ignore writes
      clr[`FLAG_SYS_ERR]     = regWdata[`BIT_SYS_ERR];
      clr[`FLAG_MABORT_RX]   = regWdata[`BIT_MABORT_RX];
      clr[`FLAG_TABORT_RX]   = regWdata[`BIT_TABORT_RX];
      clr[`FLAG_TABORT_TX]   = regWdata[`BIT_TABORT_TX];
      clr[`FLAG_INIT_PARITY] = regWdata[`BIT_INIT_PARITY];
    end else if (regWr && regAddr == `OFS_IRQ_CLEAR) begin
      clr = regWdata[`NUM_FLAGS-1:0];
    end
  end

  always_comb begin
    // an event in the clearing cycle wins over the clear
    next_flags      = (flags & ~clr) | ev;
    next_parity_response_enable      = parity_response_enable;
    next_irqEn      = irqEn;
    next_pciClkPrev = pciClkS;
    next_regRdata   = 32'h0000_0000;
    if (regWr && regAddr == `OFS_STATUS_CMD) begin
      next_parity_response_enable = regWdata[`BIT_PARITY_RESP];
    end
    if (regWr && regAddr == `OFS_IRQ_ENABLE) begin
      next_irqEn = regWdata[`NUM_FLAGS-1:0];
    end
    if (regRd) begin
      case (regAddr)
        `OFS_STATUS_CMD: next_regRdata = statusWord;
        `OFS_IRQ_STATUS: next_regRdata[`NUM_FLAGS-1:0] = flags;
        `OFS_IRQ_ENABLE: next_regRdata[`NUM_FLAGS-1:0] = irqEn;
        default:         next_regRdata = 32'h0000_0000;
      endcase
    end
    next_irq = |(next_flags & next_irqEn);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flags      <= '0;
      irqEn      <= '0;
      parity_response_enable      <= 1'b0;
      pciClkPrev <= 1'b0;
      regRdata   <= 32'h0000_0000;
      irq        <= 1'b0;
    end else begin
      flags      <= next_flags;
      irqEn      <= next_irqEn;
      parity_response_enable      <= next_parity_response_enable;
      pciClkPrev <= next_pciClkPrev;
      regRdata   <= next_regRdata;
      irq        <= next_irq;
    end
  end

  // ************************************************************
  // target decode timing
  // ************************************************************
  devsel_timer u_devsel (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .pciEdge    (pciEdge),
    .frameLow   (frameLow),
    .busCmd     (cmdS),
    .addrHit    (hitS),
    .transEnd   (endS),
    .devselNOut (devselNOut),
    .devselOe   (devselOe)
  );

  // ************************************************************
  // checks
  // ************************************************************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_sys_err_set: assert property (
    pciEdge && serrLow |=> flags[`FLAG_SYS_ERR])
    else $error("system error flag not set after serr");
  a_mabort_special: assert property (
    pciEdge && mAbortS && specialS && !flags[`FLAG_MABORT_RX]
    |=> !flags[`FLAG_MABORT_RX])
    else $error("special cycle master abort set the flag");
  a_mabort_set: assert property (
    pciEdge && mAbortS && !specialS |=> flags[`FLAG_MABORT_RX])
    else $error("master abort flag not set");
  a_tabort_rx: assert property (
    $rose(flags[`FLAG_TABORT_RX]) |-> $past(tAbortInS && masterS))
    else $error("target abort received flag without cause");
  a_tabort_tx: assert property (
    pciEdge && tAbortOutS && !masterS |=> flags[`FLAG_TABORT_TX])
    else $error("target abort signalled flag not set");
  a_parity_gate: assert property (
    $rose(flags[`FLAG_INIT_PARITY]) |-> $past(parity_response_enable) && $past(masterS)
      && $past(perrLow))
    else $error("initiator parity flag set without all conditions");
  a_w1c_clear: assert property (
    regWr && regAddr == `OFS_STATUS_CMD && regWdata[`BIT_MABORT_RX]
    && !ev[`FLAG_MABORT_RX] |=> !flags[`FLAG_MABORT_RX])
    else $error("write one did not clear master abort flag");
  a_fixed_bits: assert property (
    regRd && regAddr == `OFS_STATUS_CMD |=>
      regRdata[`DEVSEL_HI:`DEVSEL_LO] == `DEVSEL_MEDIUM
      && regRdata[`BIT_B2B_CAP] && regRdata[`BIT_66M_CAP]
      && regRdata[`BIT_CAP_LIST] && regRdata[`BIT_RSVD_HI] == 1'b0
      && regRdata[`RSVD_LOW_HI:`RSVD_LOW_LO] == 10'h000)
    else $error("fixed or reserved status bits read wrong");
  a_irq_level: assert property (
    irq == |(flags & irqEn))
    else $error("interrupt does not follow enabled flags");
  a_sys_err_quiet: assert property (
    !flags[`FLAG_SYS_ERR] && !(pciEdge && serrLow)
    |=> !flags[`FLAG_SYS_ERR])
    else $error("system error flag set without serr");
  a_sys_err_sticky: assert property (
    flags[`FLAG_SYS_ERR] && !clr[`FLAG_SYS_ERR] |=> flags[`FLAG_SYS_ERR])
    else $error("system error flag lost without a clear");
  a_sys_err_clear: assert property (
    clr[`FLAG_SYS_ERR] && !ev[`FLAG_SYS_ERR] |=> !flags[`FLAG_SYS_ERR])
    else $error("clearing did not reset system error flag");
  a_mabort_quiet: assert property (
    !flags[`FLAG_MABORT_RX] && !(pciEdge && mAbortS)
    |=> !flags[`FLAG_MABORT_RX])
    else $error("master abort flag set without an abort");
  a_tabort_rx_set: assert property (
    pciEdge && tAbortInS && masterS |=> flags[`FLAG_TABORT_RX])
    else $error("target abort received flag not set");
  a_tabort_rx_clear: assert property (
    clr[`FLAG_TABORT_RX] && !ev[`FLAG_TABORT_RX]
    |=> !flags[`FLAG_TABORT_RX])
    else $error("clearing did not reset target abort received flag");
  a_tabort_tx_quiet: assert property (
    !flags[`FLAG_TABORT_TX] && !(pciEdge && tAbortOutS)
    |=> !flags[`FLAG_TABORT_TX])
    else $error("target abort signalled flag set without an abort");
  a_tabort_tx_clear: assert property (
    clr[`FLAG_TABORT_TX] && !ev[`FLAG_TABORT_TX]
    |=> !flags[`FLAG_TABORT_TX])
    else $error("write one did not clear target abort signalled flag");
  a_parity_target: assert property (
    !masterS && !flags[`FLAG_INIT_PARITY] |=> !flags[`FLAG_INIT_PARITY])
    else $error("initiator parity flag set while acting as target");
  a_parity_off: assert property (
    !parity_response_enable && !flags[`FLAG_INIT_PARITY] |=> !flags[`FLAG_INIT_PARITY])
    else $error("initiator parity flag set with response disabled");
  a_parity_clear: assert property (
    clr[`FLAG_INIT_PARITY] && !ev[`FLAG_INIT_PARITY]
    |=> !flags[`FLAG_INIT_PARITY])
    else $error("write one did not clear initiator parity flag");

  // ************************************************************
  // register port checks
  // ************************************************************
  a_rdata_idle: assert property (
    !regRd |=> regRdata == 32'h0000_0000)
    else $error("read data not zero outside a read answer");
  a_parity_enable_read: assert property (
    regRd && regAddr == `OFS_STATUS_CMD
    |=> regRdata[`BIT_PARITY_RESP] == $past(parity_response_enable))
    else $error("parity response enable reads back wrong");

endmodule

// ==== tb/pci_agent_model.sv ====
// other pci agents: free running pci clock, frame, command, decode hit,
// end of transaction and the pulled-up error pins.
// assumes the bench calls one task at a time.
`timescale 1ns/100ps

module pci_agent_model (
  // pci clock and pins
  output logic       pciClk,
  output logic       frameN,
  output logic [3:0] busCmd,
  output logic       serrN,
  output logic       perrN,
  // same-clock decode lines
  output logic       addrHit,
  output logic       transEnd
);
  // ********
  // clock
  // ********
  // odd start offset keeps the pci clock out of phase with clk_sys
  initial begin
    pciClk   = 1'b0;
    frameN   = 1'b1;
    busCmd   = 4'h0;
    serrN    = 1'b1;
    perrN    = 1'b1;
    addrHit  = 1'b0;
    transEnd = 1'b0;
    #137;
    forever #400 pciClk = ~pciClk;
  end

  // ********
  // bus phases
  // ********
  // changes land on the falling edge so they stand across the rise
  task automatic addr_phase(input logic [3:0] cmd);
    @(negedge pciClk);
    frameN  <= 1'b0;
    busCmd  <= cmd;
    addrHit <= 1'b1;
    @(negedge pciClk);
    addrHit <= 1'b0;
    busCmd  <= ~cmd;
  endtask

  task automatic end_phase();
    @(negedge pciClk);
    frameN   <= 1'b1;
    transEnd <= 1'b1;
    @(negedge pciClk);
    transEnd <= 1'b0;
  endtask

  // error pins are pulled up, so a release reads high
  task automatic err_pins(input logic serr, input logic perr);
    serrN <= ~serr;
    perrN <= ~perr;
  endtask
endmodule

// ==== tb/tb.sv ====
// bench for the pci status flag block: register port, events, interrupt
// and target decode timing against a model of the other pci agents.
// assumes logic/ on the include path and the design compiled first.
`timescale 1ns/100ps

`include "pci_status_defines.svh"

module tb;
  // ********
  // signals
  // ********
  logic        clk_sys;
  logic        rst;
  logic [7:0]  regAddr;
  logic [31:0] regWdata;
  logic        regWr;
  logic        regRd;
  logic [31:0] regRdata;
  logic        irq;
  logic        pciClk;
  logic        serrN;
  logic        perrN;
  logic        frameN;
  logic [3:0]  busCmd;
  logic        addrHit;
  logic        transEnd;
  logic        isMaster;
  logic        specialCycle;
  logic        masterAbort;
  logic        targetAbortIn;
  logic        targetAbortOut;
  logic        devselNOut;
  logic        devselOe;
  logic [31:0] pe;
  int          badCount;
  int          numChecks;
  int          cycles;
  // medium speed code and the three fixed capability bits
  localparam logic [31:0] BASE = 32'h02b0_0000;

  pci_status_flags i_dut (
    .clk_sys       (clk_sys),
    .rst           (rst),
    .regAddr       (regAddr),
    .regWdata      (regWdata),
    .regWr         (regWr),
    .regRd         (regRd),
    .regRdata      (regRdata),
    .irq           (irq),
    .pciClk        (pciClk),
    .serrN         (serrN),
    .perrN         (perrN),
    .frameN        (frameN),
    .busCmd        (busCmd),
    .isMaster      (isMaster),
    .specialCycle  (specialCycle),
    .masterAbort   (masterAbort),
    .targetAbortIn (targetAbortIn),
    .targetAbortOut(targetAbortOut),
    .addrHit       (addrHit),
    .transEnd      (transEnd),
    .devselNOut    (devselNOut),
    .devselOe      (devselOe)
  );

  pci_agent_model i_peer (
    .pciClk  (pciClk),
    .frameN  (frameN),
    .busCmd  (busCmd),
    .serrN   (serrN),
    .perrN   (perrN),
    .addrHit (addrHit),
    .transEnd(transEnd)
  );

  // ********
  // helpers
  // ********
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      badCount++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic completeRun();
    $display("checks %0d mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk_sys);
    regWr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk_sys);
    regRd   <= 1'b0;
    #1 chk(regRdata, e);
  endtask

  // status word bits for the flag vector order of the irq registers
  function automatic logic [31:0] st(input logic [4:0] f);
    return {1'b0, f[0], f[1], f[2], f[3], 2'b00, f[4], 24'h0};
  endfunction

  function automatic logic [31:0] dv();
    return {30'h0, devselOe, devselNOut};
  endfunction

  // v is serr, perr, master, special, master abort, abort in, abort out
  task automatic fire(input logic [6:0] v);
    @(negedge pciClk);
    @(posedge clk_sys);
    {isMaster, specialCycle, masterAbort, targetAbortIn,
     targetAbortOut} <= v[4:0];
    i_peer.err_pins(v[6], v[5]);
    @(posedge pciClk);
    repeat (6) @(posedge clk_sys);
    {isMaster, specialCycle, masterAbort, targetAbortIn,
     targetAbortOut} <= 5'h0;
    i_peer.err_pins(1'b0, 1'b0);
  endtask

  task automatic flag_case(input logic [6:0] v, input logic [4:0] f);
    fire(v);
    rd(`OFS_STATUS_CMD, BASE | pe | st(f));
    rd(`OFS_IRQ_STATUS, {27'h0, f});
    wr(`OFS_STATUS_CMD, st(f) | pe);
    rd(`OFS_STATUS_CMD, BASE | pe);
  endtask

  task automatic devsel_case(input logic [3:0] cmd, input logic cfg);
    i_peer.addr_phase(cmd);
    repeat (2) @(posedge pciClk);
    #1 chk(dv(), 32'h1);
    repeat (6) @(posedge clk_sys);
    #1 chk(dv(), cfg ? 32'h1 : 32'h2);
    if (cfg) begin
      @(posedge pciClk);
      repeat (6) @(posedge clk_sys);
      #1 chk(dv(), 32'h2);
    end
    i_peer.end_phase();
    repeat (4) @(posedge clk_sys);
    #1 chk(dv(), 32'h1);
  endtask

  // ********
  // scenarios
  // ********
  task automatic test_fixed();
    rd(`OFS_STATUS_CMD, BASE);
    wr(`OFS_STATUS_CMD, 32'hffff_ffff);
    pe = 32'h40;
    rd(`OFS_STATUS_CMD, BASE | pe);
    rd(8'h20, 32'h0);
    rd(`OFS_IRQ_ENABLE, 32'h0);
  endtask

  task automatic test_flags();
    flag_case(7'b100_0000, 5'h01);
    flag_case(7'b001_0100, 5'h02);
    flag_case(7'b001_1100, 5'h00);
    flag_case(7'b001_0010, 5'h04);
    flag_case(7'b000_0001, 5'h08);
    flag_case(7'b011_0000, 5'h10);
    flag_case(7'b010_0000, 5'h00);
    pe = 32'h0;
    wr(`OFS_STATUS_CMD, pe);
    flag_case(7'b011_0000, 5'h00);
  endtask

  task automatic test_irq();
    wr(`OFS_IRQ_ENABLE, 32'h1);
    rd(`OFS_IRQ_ENABLE, 32'h1);
    fire(7'b100_0000);
    #1 chk({31'h0, irq}, 32'h1);
    wr(`OFS_IRQ_CLEAR, 32'h1);
    @(posedge clk_sys);
    #1 chk({31'h0, irq}, 32'h0);
    rd(`OFS_IRQ_STATUS, 32'h0);
    rd(`OFS_IRQ_CLEAR, 32'h0);
    wr(`OFS_IRQ_ENABLE, 32'h0);
    fire(7'b100_0000);
    #1 chk({31'h0, irq}, 32'h0);
    wr(`OFS_IRQ_STATUS, 32'h1f);
    rd(`OFS_IRQ_STATUS, 32'h1);
    wr(`OFS_IRQ_CLEAR, 32'h1);
  endtask

  task automatic test_devsel();
    devsel_case(4'h6, 1'b0);
    devsel_case(4'h7, 1'b0);
    devsel_case(`CMD_CFG_READ, 1'b1);
    devsel_case(`CMD_CFG_WRITE, 1'b1);
  endtask

  task automatic test_reset();
    fire(7'b100_0000);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(`OFS_STATUS_CMD, BASE);
  endtask

  // ********
  // run
  // ********
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // the whole run needs well under this many cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      badCount++;
      $display("Error at %0t: run did not finish in time", $time);
      completeRun();
    end
  end

  initial begin
    rst            = 1'b1;
    regAddr        = 8'h0;
    regWdata       = 32'h0;
    regWr          = 1'b0;
    regRd          = 1'b0;
    isMaster       = 1'b0;
    specialCycle   = 1'b0;
    masterAbort    = 1'b0;
    targetAbortIn  = 1'b0;
    targetAbortOut = 1'b0;
    pe             = 32'h0;
    badCount       = 0;
    numChecks      = 0;
    cycles         = 0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    test_fixed();
    test_flags();
    test_irq();
    test_devsel();
    test_reset();
    completeRun();
  end
endmodule
